// >>> core/can_rx_flag_pkg.sv
// Constants, register map and state codes for the receive flag and enable block.
// Assumes a 32-bit APB slave with byte addresses of four times the register index.
package can_rx_flag_pkg;

    // Bus and error counter widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 9;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL  = 8'h00;
    localparam logic [7:0] IDX_FLAGS = 8'h04;
    localparam logic [7:0] IDX_IER   = 8'h05;

    // Reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] IER_RST   = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // Flag and enable bit positions (same layout in both registers), then control register bits
    localparam int unsigned WUP_BIT    = 7;
    localparam int unsigned CSC_BIT    = 6;
    localparam int unsigned RX_ERROR_STATE_LSB  = 4;
    localparam int unsigned TX_ERROR_STATE_LSB  = 2;
    localparam int unsigned OVR_BIT    = 1;
    localparam int unsigned RXF_BIT    = 0;
    localparam int unsigned INIT_REQUEST_BIT = 0;
    localparam int unsigned INIT_ACKNOWLEDGE_BIT = 1;

    // Error counter thresholds
    localparam logic [8:0] WARN_LIMIT   = 9'h060;
    localparam logic [8:0] ERR_LIMIT    = 9'h080;
    localparam logic [8:0] BUSOFF_LIMIT = 9'h0FF;

    typedef enum logic [1:0] {
        ST_OK     = 2'h0,
        ST_WARN   = 2'h1,
        ST_ERR    = 2'h2,
        ST_BUSOFF = 2'h3
    } err_state_t;

    typedef enum logic [1:0] {
        SENS_NONE   = 2'h0,
        SENS_BUSOFF = 2'h1,
        SENS_ERR    = 2'h2,
        SENS_ALL    = 2'h3
    } sens_t;

    typedef enum logic [1:0] {
        APB_IDLE = 2'h1,
        APB_DONE = 2'h2
    } apb_state_t;

    // Byte address of a register index
    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        return {idx[5:0], 2'h0};
    endfunction

    // Does a state change count at the chosen sensitivity
    function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] old_st, input logic [1:0] new_st);
        logic hit;
        hit = 1'b0;
        case (sens)
            SENS_BUSOFF: hit = (old_st == ST_BUSOFF) || (new_st == ST_BUSOFF);
            SENS_ERR:    hit = (old_st >= ST_ERR) || (new_st >= ST_ERR);
            SENS_ALL:    hit = 1'b1;
            default:     hit = 1'b0;
        endcase
        return hit && (old_st != new_st);
    endfunction

endpackage

// >>> core/rx_state_tracker.sv
// Receiver and transmitter error state tracking with status-change events.
// Assumes error counters come from logic on pclk; no synchronisers needed.
`timescale 1ns/10ps
module rx_state_tracker
    import can_rx_flag_pkg::*;
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    input  wire logic [can_rx_flag_pkg::CNT_W-1:0] tx_err_count,
    input  wire logic [can_rx_flag_pkg::CNT_W-1:0] rx_err_count,
    input  wire logic                          csc_pending,
    input  wire logic [1:0]                    rx_sens,
    input  wire logic [1:0]                    tx_sens,
    output logic [1:0]                         rx_state,
    output logic [1:0]                         tx_state,
    output logic                               csc_event
);
    logic [1:0] rx_state_q;
    logic [1:0] tx_state_q;
    logic       csc_event_q;
    logic [1:0] tx_now;
    logic [1:0] rx_now;
    logic       update;

    // Live state from the counters; bus-off only past 255 transmit errors
    always_comb
    begin
        if (tx_err_count > BUSOFF_LIMIT)
            tx_now = ST_BUSOFF;
        else if (tx_err_count >= ERR_LIMIT)
            tx_now = ST_ERR;
        else if (tx_err_count >= WARN_LIMIT)
            tx_now = ST_WARN;
        else
            tx_now = ST_OK;
        if (tx_now == ST_BUSOFF)
            rx_now = ST_BUSOFF;
        else if (tx_state_q == ST_BUSOFF)
            rx_now = ST_OK;
        else if (rx_err_count >= ERR_LIMIT)
            rx_now = ST_ERR;
        else if (rx_err_count >= WARN_LIMIT)
            rx_now = ST_WARN;
        else
            rx_now = ST_OK;
    end

    // Frozen while a change is pending, so software reads a consistent pair
    assign update = !csc_pending && !csc_event_q && ((tx_now != tx_state_q) || (rx_now != rx_state_q));

    // Shown states; init mode does not touch them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state_q  <= ST_OK;
            tx_state_q  <= ST_OK;
            csc_event_q <= 1'b0;
        end
        else if (ce)
        begin
            csc_event_q <= update && (sens_hit(rx_sens, rx_state_q, rx_now) || sens_hit(tx_sens, tx_state_q, tx_now));
            if (update)
            begin
                rx_state_q <= rx_now;
                tx_state_q <= tx_now;
            end
        end
    end

    assign rx_state  = rx_state_q;
    assign tx_state  = tx_state_q;
    assign csc_event = csc_event_q;

    a_busoff_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && update && tx_err_count > BUSOFF_LIMIT) |=> (tx_state_q == ST_BUSOFF && rx_state_q == ST_BUSOFF))
        else $error("bus-off not shown in both state fields");
    a_rx_skip_ok: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(tx_state_q) == ST_BUSOFF && tx_state_q != ST_BUSOFF) |-> rx_state_q == ST_OK)
        else $error("receiver did not skip to ok on bus-off exit");

endmodule

// >>> core/can_rx_flag_irq_enable.sv
// Receive flag register, receive interrupt enable register and their APB slave.
// Assumes FIFO, wake-up and overrun events come from logic on pclk.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps

// Behaviour
// - Data overrun sets flag bit 1; error interrupt pending while set and enabled.
// - Moving a FIFO message into the foreground buffer sets flag bit 0.
// - Only correctly received messages reach the foreground buffer.
// - No shift into the foreground buffer while the full flag is set.
// - Receive interrupt pending while full flag set and its enable on.
// - Bus-off only past 255 transmit errors, shown in both state fields.
// - Leaving transmit bus-off forces the receiver state to ok.
// - State fields keep their values through initialization mode.
// - Eight-bit enable register at index 0x0005, all bits reset to zero.
// - Enable bits 7, 6, 1 and 0 held in reset while init request and acknowledge both set.
// - Enable register writable only outside init mode, readable always.
// - Sensitivity fields keep their values through initialization mode.
// - Enable bit 7 gates the wake-up interrupt request.
// - Enable bit 6 gates status-change error interrupt requests.
// - Writing one clears a flag, zero does nothing; state fields read-only.
// - Overrun enable bit gates the overrun error interrupt request.
// - Sensitivity field picks which state changes raise a status-change event.
module can_rx_flag_irq_enable
    import can_rx_flag_pkg::*;
(
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               ce,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [can_rx_flag_pkg::ADDR_W-1:0] paddr,
    input  wire logic [can_rx_flag_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                         pstrb,
    output logic      [can_rx_flag_pkg::DATA_W-1:0] prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               overrun_event,
    input  wire logic                               wakeup_event,
    input  wire logic                               fifo_msg_avail,
    input  wire logic                               fifo_msg_ok,
    input  wire logic [can_rx_flag_pkg::CNT_W-1:0]  tx_err_count,
    input  wire logic [can_rx_flag_pkg::CNT_W-1:0]  rx_err_count,
    output logic                                    fifo_shift,
    output logic                                    fifo_drop,
    output logic                                    init_acknowledge,
    output logic                                    irq_wakeup,
    output logic                                    irq_error,
    output logic                                    irq_rx
);
    apb_state_t               apb_state_q;
    logic [DATA_W-1:0]        prdata_q;
    logic                     pready_q;
    logic                     pslverr_q;
    logic                     init_request_q;
    logic                     init_ack_q;
    logic                     init_mode;
    logic                     wakeup_flag_q;
    logic                     status_change_flag_q;
    logic                     overrun_flag_q;
    logic                     rx_full_flag_q;
    logic                     wakeup_irq_en_q;
    logic                     status_change_irq_en_q;
    logic [1:0]               rx_state_sensitivity_q;
    logic [1:0]               tx_state_sensitivity_q;
    logic                     overrun_irq_en_q;
    logic                     rx_full_irq_en_q;
    logic                     fifo_shift_q;
    logic                     fifo_drop_q;
    logic                     irq_wakeup_q;
    logic                     irq_error_q;
    logic                     irq_rx_q;
    logic [1:0]               rx_error_state;
    logic [1:0]               tx_error_state;
    logic                     csc_event;
    logic                     wr_fire;
    logic                     wr_ctrl;
    logic                     wr_flags;
    logic                     wr_ier;
    logic                     addr_hit;
    logic [7:0]               flags_view;
    logic [7:0]               ier_view;
    logic [DATA_W-1:0]        rd_word;
    logic [7:0]               clr_mask;
    logic                     shift_ok;

    // Init mode needs both request and acknowledge
    assign init_mode = init_request_q && init_ack_q;

    // Write strobes fire at the edge where pready is sampled high
    assign wr_fire  = (apb_state_q == APB_DONE) && psel && penable && pwrite && pstrb[0];
    assign wr_ctrl  = wr_fire && (paddr == reg_addr(IDX_CTRL));
    assign wr_flags = wr_fire && (paddr == reg_addr(IDX_FLAGS)) && !init_mode;
    assign wr_ier   = wr_fire && (paddr == reg_addr(IDX_IER)) && !init_mode;
    assign addr_hit = (paddr == reg_addr(IDX_CTRL)) || (paddr == reg_addr(IDX_FLAGS))
                   || (paddr == reg_addr(IDX_IER));

    // One-cleared mask; state field bits never clear by write
    assign clr_mask = wr_flags ? pwdata[7:0] : 8'h00;

    // Register views for reads
    assign flags_view = {wakeup_flag_q, status_change_flag_q, rx_error_state, tx_error_state,
                         overrun_flag_q, rx_full_flag_q};
    assign ier_view   = {wakeup_irq_en_q, status_change_irq_en_q, rx_state_sensitivity_q,
                         tx_state_sensitivity_q, overrun_irq_en_q, rx_full_irq_en_q};

    // Read mux; unmapped reads return zero
    always_comb
    begin
        rd_word = '0;
        if (paddr == reg_addr(IDX_CTRL))
        begin
            rd_word[INIT_REQUEST_BIT] = init_request_q;
            rd_word[INIT_ACKNOWLEDGE_BIT] = init_ack_q;
        end
        else if (paddr == reg_addr(IDX_FLAGS))
            rd_word[7:0] = flags_view;
        else if (paddr == reg_addr(IDX_IER))
            rd_word[7:0] = ier_view;
    end

    // APB handshake: one wait state, then pready for one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_state_q <= APB_IDLE;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            prdata_q    <= '0;
        end
        else if (ce)
        begin
            case (apb_state_q)
                APB_IDLE:
                begin
                    if (psel && penable)
                    begin
                        apb_state_q <= APB_DONE;
                        pready_q    <= 1'b1;
                        pslverr_q   <= !addr_hit;
                        prdata_q    <= pwrite ? '0 : rd_word;
                    end
                end
                APB_DONE:
                begin
                    apb_state_q <= APB_IDLE;
                    pready_q    <= 1'b0;
                    pslverr_q   <= 1'b0;
                end
                default:
                begin
                    apb_state_q <= APB_IDLE;
                    pready_q    <= 1'b0;
                    pslverr_q   <= 1'b0;
                end
            endcase
        end
    end

    // Init request is software driven; acknowledge follows a cycle later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_request_q <= CTRL_RST[INIT_REQUEST_BIT];
            init_ack_q     <= CTRL_RST[INIT_ACKNOWLEDGE_BIT];
        end
        else if (ce)
        begin
            if (wr_ctrl)
                init_request_q <= pwdata[INIT_REQUEST_BIT];
            init_ack_q <= init_request_q;
        end
    end

    // Enable register; sensitivity fields survive init mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wakeup_irq_en_q        <= IER_RST[WUP_BIT];
            status_change_irq_en_q <= IER_RST[CSC_BIT];
            rx_state_sensitivity_q <= IER_RST[RX_ERROR_STATE_LSB+:2];
            tx_state_sensitivity_q <= IER_RST[TX_ERROR_STATE_LSB+:2];
            overrun_irq_en_q       <= IER_RST[OVR_BIT];
            rx_full_irq_en_q       <= IER_RST[RXF_BIT];
        end
        else if (ce)
        begin
            if (init_mode)
            begin
                wakeup_irq_en_q        <= IER_RST[WUP_BIT];
                status_change_irq_en_q <= IER_RST[CSC_BIT];
                overrun_irq_en_q       <= IER_RST[OVR_BIT];
                rx_full_irq_en_q       <= IER_RST[RXF_BIT];
            end
            else if (wr_ier)
            begin
                wakeup_irq_en_q        <= pwdata[WUP_BIT];
                status_change_irq_en_q <= pwdata[CSC_BIT];
                rx_state_sensitivity_q <= pwdata[RX_ERROR_STATE_LSB+:2];
                tx_state_sensitivity_q <= pwdata[TX_ERROR_STATE_LSB+:2];
                overrun_irq_en_q       <= pwdata[OVR_BIT];
                rx_full_irq_en_q       <= pwdata[RXF_BIT];
            end
        end
    end

    // Shift only into a free buffer and not while the last pulse is in flight
    assign shift_ok = !rx_full_flag_q && !fifo_shift_q && !fifo_drop_q && !init_mode && fifo_msg_avail;

    // FIFO hand-off: good messages shift, bad ones are dropped unseen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_shift_q <= 1'b0;
            fifo_drop_q  <= 1'b0;
        end
        else if (ce)
        begin
            fifo_shift_q <= shift_ok && fifo_msg_ok;
            fifo_drop_q  <= shift_ok && !fifo_msg_ok;
        end
    end

    // Event flags: a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wakeup_flag_q        <= FLAGS_RST[WUP_BIT];
            status_change_flag_q <= FLAGS_RST[CSC_BIT];
            overrun_flag_q       <= FLAGS_RST[OVR_BIT];
            rx_full_flag_q       <= FLAGS_RST[RXF_BIT];
        end
        else if (ce)
        begin
            if (init_mode)
            begin
                wakeup_flag_q        <= FLAGS_RST[WUP_BIT];
                status_change_flag_q <= FLAGS_RST[CSC_BIT];
                overrun_flag_q       <= FLAGS_RST[OVR_BIT];
                rx_full_flag_q       <= FLAGS_RST[RXF_BIT];
            end
            else
            begin
                wakeup_flag_q        <= wakeup_event || (wakeup_flag_q && !clr_mask[WUP_BIT]);
                status_change_flag_q <= csc_event || (status_change_flag_q && !clr_mask[CSC_BIT]);
                overrun_flag_q       <= overrun_event || (overrun_flag_q && !clr_mask[OVR_BIT]);
                rx_full_flag_q       <= (shift_ok && fifo_msg_ok)
                                     || (rx_full_flag_q && !clr_mask[RXF_BIT]);
            end
        end
    end

    // State fields live in the tracker and ignore init mode
    rx_state_tracker u_tracker (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .tx_err_count (tx_err_count),
        .rx_err_count (rx_err_count),
        .csc_pending  (status_change_flag_q),
        .rx_sens      (rx_state_sensitivity_q),
        .tx_sens      (tx_state_sensitivity_q),
        .rx_state     (rx_error_state),
        .tx_state     (tx_error_state),
        .csc_event    (csc_event)
    );

    // Interrupt requests, registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_wakeup_q <= 1'b0;
            irq_error_q  <= 1'b0;
            irq_rx_q     <= 1'b0;
        end
        else if (ce)
        begin
            irq_wakeup_q <= wakeup_flag_q && wakeup_irq_en_q;
            irq_error_q  <= (status_change_flag_q && status_change_irq_en_q)
                         || (overrun_flag_q && overrun_irq_en_q);
            irq_rx_q     <= rx_full_flag_q && rx_full_irq_en_q;
        end
    end

    // Output drive
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign fifo_shift       = fifo_shift_q;
    assign fifo_drop        = fifo_drop_q;
    assign init_acknowledge = init_ack_q;
    assign irq_wakeup       = irq_wakeup_q;
    assign irq_error        = irq_error_q;
    assign irq_rx           = irq_rx_q;

    a_ovr_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && overrun_event && !init_mode) |=> overrun_flag_q)
        else $error("overrun event did not set its flag");
    a_shift_sets_full: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_shift_q |-> rx_full_flag_q)
        else $error("shift without full flag");
    a_bad_msg_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !fifo_msg_ok) |=> !fifo_shift_q)
        else $error("bad message shifted into foreground");
    a_full_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && rx_full_flag_q) |=> !fifo_shift_q)
        else $error("shift while buffer full");
    a_rx_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> (irq_rx_q == $past(rx_full_flag_q && rx_full_irq_en_q)))
        else $error("receive interrupt does not follow flag and enable");
    a_ier_init_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && init_mode) |=> (!wakeup_irq_en_q && !status_change_irq_en_q && !overrun_irq_en_q
                               && !rx_full_irq_en_q))
        else $error("enable bits not held in reset during init");
    a_sens_init_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && init_mode) |=> ($stable(rx_state_sensitivity_q) && $stable(tx_state_sensitivity_q)))
        else $error("sensitivity changed during init");
    a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !wakeup_irq_en_q) |=> !irq_wakeup_q)
        else $error("wake-up request while disabled");
    a_err_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !status_change_irq_en_q && !overrun_irq_en_q) |=> !irq_error_q)
        else $error("error request while disabled");
    a_ovr_w1c: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr_flags && pwdata[OVR_BIT] && !overrun_event) |=> !overrun_flag_q)
        else $error("write one did not clear overrun flag");
    // Positive side of the gates: a set wake-up or overrun flag with its enable must reach the pin; the full flag holds until cleared
    a_wake_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wakeup_flag_q && wakeup_irq_en_q) |=> irq_wakeup_q)
        else $error("wake-up request missing while enabled");
    a_ovr_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && overrun_flag_q && overrun_irq_en_q) |=> irq_error_q)
        else $error("overrun request missing while enabled");
    a_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && rx_full_flag_q && !clr_mask[RXF_BIT] && !init_mode) |=> rx_full_flag_q)
        else $error("full flag dropped without a clear");

endmodule

// >>> verif/fifo_model.sv
// Receive FIFO model feeding the flag block; holds one ok bit per message.
// Assumes pushes come from the bench on pclk; pops on shift or drop pulses.
`timescale 1ns/10ps
module fifo_model
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic push,
    input  wire logic push_ok,
    input  wire logic fifo_shift,
    input  wire logic fifo_drop,
    output logic      fifo_msg_avail,
    output logic      fifo_msg_ok
);
    logic q[$];
    // Pop lands at the pulse edge, so avail drops in the cycle after the pulse
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q.delete();
            fifo_msg_avail <= 1'b0;
            fifo_msg_ok    <= 1'b0;
        end
        else
        begin
            if (fifo_shift || fifo_drop)
                q.pop_front();
            if (push)
                q.push_back(push_ok);
            fifo_msg_avail <= (q.size() > 0);
            // Empty queue toggles ok so a stale value is never trusted
            fifo_msg_ok    <= (q.size() > 0) ? q[0] : ~fifo_msg_ok;
        end
    end
endmodule

// >>> verif/tb.sv
// Self-checking bench: APB master, FIFO model and event stimulus for the flag block.
// Assumes one 20 MHz clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
    import can_rx_flag_pkg::*;
    localparam logic [7:0] A_C = 8'(IDX_CTRL * 4);
    localparam logic [7:0] A_F = 8'(IDX_FLAGS * 4);
    localparam logic [7:0] A_E = 8'(IDX_IER * 4);
    logic ce = 1;
    logic [3:0] pstrb = 4'hF;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, push = 0, push_ok = 0;
    logic overrun_event = 0, wakeup_event = 0, fifo_msg_avail, fifo_msg_ok, pready, pslverr;
    logic fifo_shift, fifo_drop, init_acknowledge, irq_wakeup, irq_error, irq_rx, se;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [8:0] tx_err_count = 0, rx_err_count = 0;
    int error_cnt = 0, checks = 0, cyc = 0, nshift = 0, ndrop = 0;
    can_rx_flag_irq_enable i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .overrun_event, .wakeup_event,
        .fifo_msg_avail, .fifo_msg_ok, .tx_err_count, .rx_err_count, .fifo_shift, .fifo_drop,
        .init_acknowledge, .irq_wakeup, .irq_error, .irq_rx);
    fifo_model i_fifo (.pclk, .presetn, .push, .push_ok, .fifo_shift, .fifo_drop,
        .fifo_msg_avail, .fifo_msg_ok);
    // Clock, cycle limit and pulse counters
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        nshift += (fifo_shift === 1'b1);
        ndrop += (fifo_drop === 1'b1);
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        `CHK(n, e, rd)
    endtask
    task automatic pushm(input logic ok);
        @(posedge pclk);
        push <= 1; push_ok <= ok;
        @(posedge pclk);
        push <= 0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_reset();
        rdchk("ctrl", A_C, 0);
        rdchk("flags", A_F, 0);
        rdchk("ier", A_E, 0);
        apb(0, 8'h3C, 0);
        `CHK("slverr", 1'b1, se)
        $display("test reset done");
    endtask
    task automatic t_rx();
        apb(1, A_E, 32'h01);
        pushm(1);
        `CHK("shifts", 1, nshift)
        `CHK("irq_rx", 1'b1, irq_rx)
        pushm(1);
        pushm(0);
        `CHK("held", 1, nshift)
        apb(1, A_F, 32'h01);
        repeat (4) @(posedge pclk);
        `CHK("shifts2", 2, nshift)
        rdchk("full2", A_F, 32'h01);
        apb(1, A_F, 32'h01);
        repeat (4) @(posedge pclk);
        `CHK("drops", 1, ndrop)
        rdchk("empty", A_F, 0);
        `CHK("irq_rx0", 1'b0, irq_rx)
        $display("test rx done");
    endtask
    task automatic t_err();
        apb(1, A_E, 32'h82);
        // Lane 0 strobe low: the write is answered but ignored
        pstrb <= 4'hE;
        apb(1, A_E, 32'h01);
        pstrb <= 4'hF;
        rdchk("lane0", A_E, 32'h82);
        // Clock enable low: an overrun pulse must leave no trace
        ce <= 0;
        @(posedge pclk);
        overrun_event <= 1;
        @(posedge pclk);
        overrun_event <= 0;
        @(posedge pclk);
        ce <= 1;
        rdchk("frozen", A_F, 0);
        @(posedge pclk);
        overrun_event <= 1; wakeup_event <= 1;
        @(posedge pclk);
        overrun_event <= 0; wakeup_event <= 0;
        repeat (3) @(posedge pclk);
        `CHK("irq_err", 1'b1, irq_error)
        `CHK("irq_wup", 1'b1, irq_wakeup)
        apb(1, A_F, 0);
        rdchk("w0", A_F, 32'h82);
        apb(1, A_F, 32'h82);
        repeat (2) @(posedge pclk);
        `CHK("irq_clr", 1'b0, irq_error | irq_wakeup)
        $display("test err done");
    endtask
    task automatic t_boff();
        apb(1, A_E, 32'h44);
        tx_err_count <= 9'd256;
        rx_err_count <= 9'd200;
        repeat (6) @(posedge pclk);
        rdchk("boff", A_F, 32'h7C);
        `CHK("irq_csc", 1'b1, irq_error)
        apb(1, A_C, 32'h01);
        repeat (3) @(posedge pclk);
        `CHK("ack", 1'b1, init_acknowledge)
        rdchk("initf", A_F, 32'h3C);
        rdchk("inite", A_E, 32'h04);
        apb(1, A_E, 32'hFF);
        rdchk("initw", A_E, 32'h04);
        apb(1, A_C, 0);
        repeat (3) @(posedge pclk);
        `CHK("ack0", 1'b0, init_acknowledge)
        apb(1, A_E, 32'h44);
        tx_err_count <= 0;
        repeat (6) @(posedge pclk);
        rdchk("exit", A_F, 32'h40);
        $display("test busoff done");
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_rx();
        t_err();
        t_boff();
        end_of_test();
    end
endmodule
